// File: hdl/isp_core.v
// serial programming port with flash, data eeprom, fuses and lock bits
`include "isp_map.vh"

module isp_core #(
  parameter PAGE_WAIT_CYC = `WAIT_CYC(`PAGE_WRITE_WAIT_US),
  parameter BYTE_WAIT_CYC = `WAIT_CYC(`BYTE_WRITE_WAIT_US),
  parameter ERASE_WAIT_CYC = `WAIT_CYC(`ERASE_WAIT_US),
  parameter CONFIG_WAIT_CYC = `WAIT_CYC(`CONFIG_WRITE_WAIT_US),
  // arbitrary identification values
  parameter [7:0] SIG0 = 8'h5A,
  parameter [7:0] SIG1 = 8'h11,
  parameter [7:0] SIG2 = 8'h22,
  parameter [7:0] CAL_BYTE = 8'h80
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // serial link pins
  input wire reset_n,
  input wire sck,
  input wire mosi,
  output reg miso,
  // status
  output reg prog_enabled,
  output reg busy
);
  // ==========================================
  // pin synchronisation
  wire [2:0] lvl;
  wire [2:0] rise;
  wire [2:0] fall;
  isp_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({reset_n, mosi, sck}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );
  wire sck_rise = rise[0];
  wire sck_fall = fall[0];
  wire mosi_s = lvl[1];
  wire in_reset = ~lvl[2];

  // ==========================================
  // storage
  reg [7:0] flash_lo [0:1023];
  reg [7:0] flash_hi [0:1023];
  reg [63:0] page_written;
  reg [7:0] eeprom [0:127];
  reg [127:0] ee_written;
  reg [7:0] buf_lo [0:15];
  reg [7:0] buf_hi [0:15];
  reg [1:0] lock;
  reg [7:0] fuse_lo;
  reg [4:0] fuse_hi;

  // ==========================================
  // shifter state
  reg [4:0] bit_cnt;
  reg [7:0] in_sr;
  reg [7:0] out_sr;
  reg [7:0] byte1;
  reg [7:0] byte2;
  reg [7:0] byte3;
  reg [18:0] wait_cnt;
  reg busy_flash;
  reg busy_ee;
  reg [5:0] busy_page;
  reg [6:0] busy_ee_addr;

  wire [7:0] next_sr = {in_sr[6:0], mosi_s};
  wire byte_done = sck_rise & (bit_cnt[2:0] == 3'h7);
  wire instr_done = sck_rise & (bit_cnt == 5'h1F);

  // ==========================================
  // read data, chosen while byte three completes
  wire [9:0] rd_word = {byte2[1:0], next_sr};
  wire [6:0] rd_ee = next_sr[6:0];
  reg [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    if (byte1[7:4] == `OP_FLASH_RD && byte1[2:0] == 3'h0) begin
      if ((busy_flash && rd_word[9:4] == busy_page) || !page_written[rd_word[9:4]]) begin
        rd_data = `ERASED_BYTE;
      end else begin
        rd_data = byte1[3] ? flash_hi[rd_word] : flash_lo[rd_word];
      end
    end else if (byte1 == `OP_EE_RD) begin
      if ((busy_ee && rd_ee == busy_ee_addr) || !ee_written[rd_ee]) begin
        rd_data = `ERASED_BYTE;
      end else begin
        rd_data = eeprom[rd_ee];
      end
    end else if (byte1 == `OP_LOCK_RD && byte2 == `OP_LOCK_RD_B2) begin
      rd_data = {6'h3F, lock};
    end else if (byte1 == `OP_LOCK_RD && byte2 == `OP_FUSE_HI_RD_B2) begin
      rd_data = {3'h7, fuse_hi};
    end else if (byte1 == `OP_FUSE_LO_RD) begin
      rd_data = fuse_lo;
    end else if (byte1 == `OP_SIG_RD) begin
      case (next_sr[1:0])
        2'h0: rd_data = SIG0;
        2'h1: rd_data = SIG1;
        2'h2: rd_data = SIG2;
        default: rd_data = 8'h00;
      endcase
    end else if (byte1 == `OP_CAL_RD) begin
      rd_data = CAL_BYTE;
    end
  end

  // ==========================================
  // serial shifter and output
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 5'h00;
      in_sr <= 8'h00;
      out_sr <= 8'h00;
      byte1 <= 8'h00;
      byte2 <= 8'h00;
      byte3 <= 8'h00;
      miso <= 1'b0;
    end else if (!in_reset) begin
      // releasing reset drops sync so a new entry restarts framing
      bit_cnt <= 5'h00;
      out_sr <= 8'h00;
      miso <= 1'b0;
    end else begin
      if (sck_rise) begin
        bit_cnt <= bit_cnt + 5'h01;
        in_sr <= next_sr;
      end
      if (byte_done) begin
        case (bit_cnt[4:3])
          2'h0: byte1 <= next_sr;
          2'h1: byte2 <= next_sr;
          2'h2: byte3 <= next_sr;
          default: byte3 <= byte3;
        endcase
        if (bit_cnt[4:3] == 2'h2) begin
          out_sr <= rd_data;
        end else begin
          out_sr <= next_sr;
        end
      end else if (sck_fall) begin
        miso <= out_sr[7];
        out_sr <= {out_sr[6:0], 1'b0};
      end
    end
  end

  // ==========================================
  // instruction execution at end of byte four
  integer i;
  wire [5:0] wr_page = {byte2[1:0], byte3[7:4]};
  wire can_write = prog_enabled & ~busy;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_enabled <= 1'b0;
      busy <= 1'b0;
      busy_flash <= 1'b0;
      busy_ee <= 1'b0;
      busy_page <= 6'h00;
      busy_ee_addr <= 7'h00;
      wait_cnt <= 19'h00000;
      page_written <= 64'h0;
      ee_written <= 128'h0;
      lock <= `LOCK_RESET;
      fuse_lo <= `FUSE_LO_RESET;
      fuse_hi <= `FUSE_HI_RESET;
      for (i = 0; i < 16; i = i + 1) begin
        buf_lo[i] <= `ERASED_BYTE;
        buf_hi[i] <= `ERASED_BYTE;
      end
    end else begin
      if (busy) begin
        wait_cnt <= wait_cnt - 19'h00001;
        if (wait_cnt == 19'h00001) begin
          busy <= 1'b0;
          busy_flash <= 1'b0;
          busy_ee <= 1'b0;
        end
      end
      if (!in_reset) begin
        prog_enabled <= 1'b0;
      end else if (instr_done) begin
        if (byte1 == `OP_ENTRY_B1 && byte2 == `OP_ENTRY_B2) begin
          prog_enabled <= 1'b1;
        end else if (can_write && byte1 == `OP_ENTRY_B1 && byte2[7:5] == `OP_ERASE_B2) begin
          page_written <= 64'h0;
          ee_written <= 128'h0;
          lock <= `LOCK_RESET;
          busy <= 1'b1;
          wait_cnt <= ERASE_WAIT_CYC[18:0];
        end else if (can_write && byte1 == `OP_ENTRY_B1 && byte2[7:5] == `OP_LOCK_W_B2) begin
          lock <= lock & next_sr[1:0];
          busy <= 1'b1;
          wait_cnt <= CONFIG_WAIT_CYC[18:0];
        end else if (can_write && byte1 == `OP_ENTRY_B1 && byte2 == `OP_FUSE_LO_W_B2) begin
          fuse_lo <= next_sr;
          busy <= 1'b1;
          wait_cnt <= CONFIG_WAIT_CYC[18:0];
        end else if (can_write && byte1 == `OP_ENTRY_B1 && byte2 == `OP_FUSE_HI_W_B2) begin
          fuse_hi <= next_sr[4:0];
          busy <= 1'b1;
          wait_cnt <= CONFIG_WAIT_CYC[18:0];
        end else if (can_write && byte1[7:4] == `OP_PAGE_LOAD && byte1[2:0] == 3'h0) begin
          if (byte1[3]) begin
            buf_hi[byte3[3:0]] <= next_sr;
          end else begin
            buf_lo[byte3[3:0]] <= next_sr;
          end
        end else if (can_write && byte1 == `OP_PAGE_WRITE) begin
          // whole page at once; reads of it are masked until the wait ends
          for (i = 0; i < 16; i = i + 1) begin
            flash_lo[{wr_page, i[3:0]}] <= buf_lo[i];
            flash_hi[{wr_page, i[3:0]}] <= buf_hi[i];
            buf_lo[i] <= `ERASED_BYTE;
            buf_hi[i] <= `ERASED_BYTE;
          end
          page_written[wr_page] <= 1'b1;
          busy_page <= wr_page;
          busy_flash <= 1'b1;
          busy <= 1'b1;
          wait_cnt <= PAGE_WAIT_CYC[18:0];
        end else if (can_write && byte1 == `OP_EE_WR) begin
          eeprom[byte3[6:0]] <= next_sr;
          ee_written[byte3[6:0]] <= 1'b1;
          busy_ee_addr <= byte3[6:0];
          busy_ee <= 1'b1;
          busy <= 1'b1;
          wait_cnt <= BYTE_WAIT_CYC[18:0];
        end
      end
    end
  end
endmodule // isp_core

// File: hdl/isp_map.vh
// constants of the serial programming port
`ifndef ISP_MAP_VH
`define ISP_MAP_VH
// ==========================================
// clock and wait times
`define MCLK_KHZ 40000
`define PAGE_WRITE_WAIT_US 4500
`define BYTE_WRITE_WAIT_US 9000
`define ERASE_WAIT_US 9000
`define CONFIG_WRITE_WAIT_US 4500
`define WAIT_CYC(us) ((us) * `MCLK_KHZ / 1000)
// ==========================================
// instruction codes
`define OP_ENTRY_B1 8'hAC
`define OP_ENTRY_B2 8'h53
`define OP_ERASE_B2 3'h4
`define OP_LOCK_W_B2 3'h7
`define OP_FUSE_LO_W_B2 8'hA0
`define OP_FUSE_HI_W_B2 8'hA8
`define OP_FLASH_RD 4'h2
`define OP_PAGE_LOAD 4'h4
`define OP_PAGE_WRITE 8'h4C
`define OP_EE_RD 8'hA0
`define OP_EE_WR 8'hC0
`define OP_LOCK_RD 8'h58
`define OP_LOCK_RD_B2 8'h00
`define OP_FUSE_HI_RD_B2 8'h08
`define OP_FUSE_LO_RD 8'h50
`define OP_SIG_RD 8'h30
`define OP_CAL_RD 8'h38
// ==========================================
// reset and erased values
`define ERASED_BYTE 8'hFF
`define LOCK_RESET 2'h3
`define FUSE_LO_RESET 8'hE1
`define FUSE_HI_RESET 5'h17
`endif

// File: hdl/isp_sync.v
// two-stage synchroniser with edge detection for the serial pins
module isp_sync #(
  parameter W = 3
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // raw pins
  input wire [W-1:0] din,
  // synchronised levels and edges
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1;
      reg s2;
      reg s3;
      // first stage feeds only the second stage
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= din[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign level[i] = s2;
      assign rise[i] = s2 & ~s3;
      assign fall[i] = ~s2 & s3;
    end
  endgenerate
endmodule // isp_sync

// File: verif/isp_core_props.sv
// assertion checker for the serial programming port
module isp_core_props #(
  parameter PAGE_WAIT_CYC = 400,
  parameter BYTE_WAIT_CYC = 600,
  parameter ERASE_WAIT_CYC = 600,
  parameter CONFIG_WAIT_CYC = 400
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // serial link
  input wire reset_n,
  input wire sck,
  input wire mosi,
  input wire miso,
  // status
  input wire prog_enabled,
  input wire busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // helper counters; the clock-edge ones saturate and busy_cnt clears when idle, so idle stretches never wrap
  reg sck_q;
  reg [3:0] since_fall;
  reg [3:0] since_rise;
  reg [5:0] rn_hist;
  // wide enough for the full-length waits, not only the shortened bench ones
  reg [19:0] busy_cnt;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      since_fall <= 4'hF;
      since_rise <= 4'hF;
      rn_hist <= 6'h00;
      busy_cnt <= 20'h00000;
    end else begin
      sck_q <= sck;
      since_fall <= (sck_q && !sck) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
      since_rise <= (!sck_q && sck) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
      rn_hist <= {rn_hist[4:0], reset_n};
      busy_cnt <= busy ? busy_cnt + 20'h00001 : 20'h00000;
    end
  end
  // =====
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_EXIT_CLEARS: assert property (rn_hist == 6'h3F |-> !prog_enabled && !miso)
    else $error("enable or output left set with reset pin high");
  AST_MISO_ON_FALL: assert property ($changed(miso) && rn_hist == 6'h00 |-> since_fall inside {[0:5]})
    else $error("output bit moved away from a clock fall");
  AST_MISO_HOLD: assert property ($rose(sck) && rn_hist == 6'h00 |=> $stable(miso) [*2])
    else $error("output bit moved after a clock rise");
  AST_BUSY_AT_END: assert property ($rose(busy) |-> since_rise inside {[0:5]})
    else $error("busy started away from a clock rise");
  AST_BUSY_NEEDS_ENABLE: assert property ($rose(busy) |-> $past(prog_enabled, 2))
    else $error("write started without programming enabled");
  AST_BUSY_SPAN: assert property ($fell(busy) |-> busy_cnt inside {[PAGE_WAIT_CYC-1:PAGE_WAIT_CYC+1],
    [BYTE_WAIT_CYC-1:BYTE_WAIT_CYC+1], [ERASE_WAIT_CYC-1:ERASE_WAIT_CYC+1], [CONFIG_WAIT_CYC-1:CONFIG_WAIT_CYC+1]})
    else $error("busy span matches no wait time");
  AST_ENABLE_IN_RESET: assert property ($rose(prog_enabled) |-> rn_hist == 6'h00)
    else $error("enable rose with reset pin high");
  AST_ENABLE_AT_END: assert property ($rose(prog_enabled) |-> since_rise inside {[0:5]})
    else $error("enable rose away from a clock rise");
  COV_ENTRY: cover property ($rose(prog_enabled));
  COV_WRITE: cover property ($fell(busy));
  COV_EXIT: cover property (rn_hist == 6'h3F);
endmodule // isp_core_props

bind isp_core isp_core_props #(.PAGE_WAIT_CYC(PAGE_WAIT_CYC), .BYTE_WAIT_CYC(BYTE_WAIT_CYC),
  .ERASE_WAIT_CYC(ERASE_WAIT_CYC), .CONFIG_WAIT_CYC(CONFIG_WAIT_CYC)) chk (.mclk(mclk), .rst(rst),
  .reset_n(reset_n), .sck(sck), .mosi(mosi), .miso(miso), .prog_enabled(prog_enabled), .busy(busy));

// File: verif/isp_prog.sv
// behavioural programmer driving the serial link
module isp_prog (
  // clock
  input wire mclk,
  // serial link
  output reg reset_n,
  output reg sck,
  output reg mosi,
  input wire miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // pins start low, clock stands still between frames
  initial begin
    reset_n = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // =====
  // one four-byte frame, msb first, four mclk per clock phase
  task xfer(input [31:0] cmd, output [31:0] rsp);
    integer i;
    begin
      for (i = 31; i >= 0; i = i - 1) begin
        mosi <= cmd[i];
        repeat (4) @(posedge mclk);
        rsp[i] = miso;
        sck <= 1'b1;
        repeat (4) @(posedge mclk);
        sck <= 1'b0;
      end
      // line released: no pull, so show the inverse
      mosi <= ~cmd[0];
      repeat (3) @(posedge mclk);
    end
  endtask
  // =====
  // reset pin level; after the initial low it is driven only from here
  task set_reset_pin(input v);
    reset_n <= v;
  endtask
endmodule // isp_prog

// File: verif/test_serial_flash_eeprom_programming.sv
// self-checking bench for the serial programming port
module test_serial_flash_eeprom_programming;
  timeunit 1ns;
  timeprecision 1ps;
  localparam PW = 400;
  localparam BW = 600;
  // arbitrary identification values
  localparam [7:0] SG0 = 8'h3C;
  localparam [7:0] SG1 = 8'h96;
  localparam [7:0] SG2 = 8'h0F;
  localparam [7:0] CAL = 8'hC3;
  reg mclk;
  reg rst;
  wire reset_n, sck, mosi, miso, prog_enabled, busy;
  integer miscompares, checks, seed, i, h;
  reg [7:0] flash [0:2047];
  reg [7:0] pbuf [0:31];
  reg [31:0] rsp;
  reg [5:0] pg;
  reg [6:0] ea;
  reg [7:0] d;
  isp_core #(.PAGE_WAIT_CYC(PW), .BYTE_WAIT_CYC(BW), .ERASE_WAIT_CYC(BW), .CONFIG_WAIT_CYC(PW),
    .SIG0(SG0), .SIG1(SG1), .SIG2(SG2), .CAL_BYTE(CAL)) uut (.mclk(mclk),
    .rst(rst), .reset_n(reset_n), .sck(sck), .mosi(mosi), .miso(miso), .prog_enabled(prog_enabled), .busy(busy));
  isp_prog prg (.mclk(mclk), .reset_n(reset_n), .sck(sck), .mosi(mosi), .miso(miso));
  // =====
  // tasks
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [7:0] b1, input [7:0] b2, input [7:0] b3, input [7:0] b4);
    prg.xfer({b1, b2, b3, b4}, rsp);
  endtask
  task idle;
    integer n;
    begin
      for (n = 0; n < 2000 && busy !== 1'b0; n = n + 1) @(posedge mclk);
      chk({7'h00, busy}, 8'h00);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // =====
  // clock, watchdog, sequence
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #(25 * 60000);
    miscompares = miscompares + 1;
    final_report;
  end
  initial begin
    rst = 1'b1;
    miscompares = 0;
    checks = 0;
    seed = 32'h1d66;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk); // power-up wait shortened
    cmd(8'hAC, 8'h53, 8'h00, 8'h00);
    chk(rsp[15:8], 8'h53);
    chk({7'h00, prog_enabled}, 8'h01);
    $display("entry done");
    pg = $random(seed);
    for (i = 0; i < 32; i = i + 1) begin
      pbuf[i] = $random(seed);
      flash[{pg, i[4:0]}] = pbuf[i];
      cmd({4'h4, i[0], 3'h0}, 8'h00, {4'h0, i[4:1]}, pbuf[i]);
    end
    cmd(8'h4C, {6'h00, pg[5:4]}, {pg[3:0], 4'hF}, 8'h00);
    cmd(8'h20, {6'h00, pg[5:4]}, {pg[3:0], 4'h3}, 8'h00);
    chk(rsp[7:0], 8'hFF);
    idle;
    for (i = 0; i < 32; i = i + 1) begin
      cmd({4'h2, i[0], 3'h0}, {6'h00, pg[5:4]}, {pg[3:0], i[4:1]}, 8'h00);
      chk(rsp[7:0], flash[{pg, i[4:0]}]);
    end
    $display("flash page done");
    ea = $random(seed);
    for (h = 0; h < 2; h = h + 1) begin
      d = h ? ~d : $random(seed);
      cmd(8'hC0, 8'h00, {1'b0, ea}, d);
      cmd(8'hA0, 8'h00, {1'b1, ea}, 8'h00);
      chk(rsp[7:0], 8'hFF);
      idle;
      cmd(8'hA0, 8'hFF, {1'b0, ea}, 8'h00);
      chk(rsp[7:0], d);
    end
    $display("eeprom done");
    d = $random(seed);
    cmd(8'hAC, 8'hA0, 8'h00, d);
    idle;
    cmd(8'h50, 8'h00, 8'h00, 8'h00);
    chk(rsp[7:0], d);
    cmd(8'hAC, 8'hA8, 8'h00, d);
    idle;
    cmd(8'h58, 8'h08, 8'h00, 8'h00);
    chk(rsp[7:0], {3'h7, d[4:0]});
    cmd(8'hAC, 8'hE0, 8'h00, 8'hFE);
    idle;
    cmd(8'h58, 8'h00, 8'h00, 8'h00);
    chk({6'h00, rsp[1:0]}, 8'h02);
    $display("fuse and lock done");
    d = $random(seed);
    cmd(8'h30, d, {d[7:2], 2'h0}, 8'h00);
    chk(rsp[7:0], SG0);
    cmd(8'h30, ~d, {d[7:2], 2'h1}, 8'h00);
    chk(rsp[7:0], SG1);
    cmd(8'h30, d, {~d[7:2], 2'h2}, 8'h00);
    chk(rsp[7:0], SG2);
    cmd(8'h38, d, 8'h00, 8'h00);
    chk(rsp[7:0], CAL);
    $display("signature done");
    cmd(8'hAC, 8'h9F, 8'hA5, 8'h5A);
    idle;
    cmd(8'h28, {6'h00, pg[5:4]}, {pg[3:0], 4'h0}, 8'h00);
    chk(rsp[7:0], 8'hFF);
    cmd(8'hA0, 8'h00, {1'b0, ea}, 8'h00);
    chk(rsp[7:0], 8'hFF);
    cmd(8'h58, 8'h00, 8'h00, 8'h00);
    chk({6'h00, rsp[1:0]}, 8'h03);
    $display("chip erase done");
    prg.set_reset_pin(1'b1);
    repeat (8) @(posedge mclk);
    chk({7'h00, prog_enabled}, 8'h00);
    $display("exit done");
    final_report;
  end
endmodule // test_serial_flash_eeprom_programming
